// file: logic/ctrl_port_pkg.sv
package ctrl_port_pkg;

  localparam int REG_ADDR_BITS = 16;
  localparam int REG_DATA_BITS = 16;
  localparam int SPI_WORD_BITS = 32;
  localparam int SPI_ADDR_MSB  = 31;
  localparam int SPI_ADDR_LSB  = 16;
  localparam int SPI_DATA_MSB  = 15;
  localparam int SPI_DATA_LSB  = 0;
  localparam int PIN_SYNC_BITS = 4;

  localparam logic [3:0] BYTE_BITS      = 4'h8;
  localparam logic       I2C_ADDR_UPPER = 1'h0;
  localparam logic [4:0] I2C_ADDR_LOWER = 5'h0A;
  localparam logic       SMALL_ADDR_SEL = 1'h0;
  localparam logic       MODE_SPI_LEVEL = 1'h1;
  localparam logic       SDA_DRIVE_LVL  = 1'h0;

  localparam logic [1:0] IDX_ADDR_HI = 2'h0;
  localparam logic [1:0] IDX_ADDR_LO = 2'h1;
  localparam logic [1:0] IDX_DATA_HI = 2'h2;
  localparam logic [1:0] IDX_DATA_LO = 2'h3;

  localparam logic [15:0] PTR_RESET = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_ACK    = 3'b010,
    ST_WRBYTE = 3'b011,
    ST_RDBYTE = 3'b100,
    ST_RDACK  = 3'b101
  } i2c_state_type;

endpackage

// file: logic/cdc_sync2.sv
module cdc_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic [WIDTH-1:0] dIn,
  output logic      [WIDTH-1:0] dOut
);

  logic [WIDTH-1:0] metaFf;
  logic [WIDTH-1:0] syncFf;

  // No reset: the strap must already be settled when reset releases
  always_ff @(posedge clock) begin
    metaFf <= dIn;
    syncFf <= metaFf;
  end

  assign dOut = syncFf;

endmodule

// file: logic/codec_control_port_slave.sv
module codec_control_port_slave #(
  parameter bit SMALL_PACKAGE = 1'b0
) (
  input  wire logic                                 clock,
  input  wire logic                                 rstn,
  input  wire logic                                 ctrlClk,
  input  wire logic                                 modeSelectPin,
  input  wire logic                                 addressBitOrChipSelectPin,
  input  wire logic                                 ctrlDataIn,
  output logic                                      ctrlDataOut,
  output logic                                      ctrlDataOeN,
  input  wire logic [ctrl_port_pkg::REG_DATA_BITS-1:0] regRdData,
  output logic      [ctrl_port_pkg::REG_ADDR_BITS-1:0] regAddr,
  output logic      [ctrl_port_pkg::REG_DATA_BITS-1:0] regWrData,
  output logic                                      regWrEn,
  output logic                                      regRdEn,
  output logic                                      spiModeActive
);
  import ctrl_port_pkg::*;

  function automatic logic [6:0] slaveAddr(input logic pinLevel);
    logic n;
    n = SMALL_PACKAGE ? SMALL_ADDR_SEL : pinLevel;
    return {I2C_ADDR_UPPER, n, I2C_ADDR_LOWER};
  endfunction

  // Returns the release level for one bit of the outgoing byte
  function automatic logic txBit(input logic [15:0] word,
                                 input logic        hi,
                                 input logic [2:0]  idx);
    logic [7:0] sel;
    sel = hi ? word[15:8] : word[7:0];
    return sel[idx];
  endfunction

  // Pin synchronisers into the device clock
  logic [PIN_SYNC_BITS-1:0] pinRaw;
  logic [PIN_SYNC_BITS-1:0] pinSync;
  logic                     sclS;
  logic                     sdaS;
  logic                     csS;
  logic                     modeS;

  assign pinRaw = {ctrlClk, ctrlDataIn, addressBitOrChipSelectPin,
                   modeSelectPin};

  cdc_sync2 #(
    .WIDTH (PIN_SYNC_BITS)
  ) u_pin_sync (
    .clock (clock),
    .dIn   (pinRaw),
    .dOut  (pinSync)
  );

  assign sclS  = pinSync[3];
  assign sdaS  = pinSync[2];
  assign csS   = pinSync[1];
  assign modeS = pinSync[0];

  // Link domain: serial shift register on the master's clock
  logic [SPI_WORD_BITS-1:0] spiShiftFf;
  logic [SPI_WORD_BITS-1:0] nxt_spiShift;

  always_comb begin
    nxt_spiShift = spiShiftFf;
    if (!addressBitOrChipSelectPin) begin
      nxt_spiShift = {spiShiftFf[SPI_WORD_BITS-2:0], ctrlDataIn};
    end
  end

  // Data path only; the frame itself defines its content
  always_ff @(posedge ctrlClk) begin
    spiShiftFf <= nxt_spiShift;
  end

  // Mode strap capture
  logic modeLockedFf;
  logic spiModeFf;
  logic nxt_modeLocked;
  logic nxt_spiMode;

  always_comb begin
    nxt_modeLocked = 1'b1;
    nxt_spiMode    = spiModeFf;
    if (!modeLockedFf) begin
      nxt_spiMode = (modeS == MODE_SPI_LEVEL) && !SMALL_PACKAGE;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      modeLockedFf <= 1'b0;
      spiModeFf    <= 1'b0;
    end else begin
      modeLockedFf <= nxt_modeLocked;
      spiModeFf    <= nxt_spiMode;
    end
  end

  logic i2cOn;
  logic spiOn;

  assign i2cOn = modeLockedFf && !spiModeFf;
  assign spiOn = modeLockedFf && spiModeFf;

  // Edge history of the synchronised pins
  logic sclPrevFf;
  logic sdaPrevFf;
  logic csPrevFf;
  logic nxt_sclPrev;
  logic nxt_sdaPrev;
  logic nxt_csPrev;

  always_comb begin
    nxt_sclPrev = sclS;
    nxt_sdaPrev = sdaS;
    nxt_csPrev  = csS;
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      sclPrevFf <= 1'b1;
      sdaPrevFf <= 1'b1;
      csPrevFf  <= 1'b1;
    end else begin
      sclPrevFf <= nxt_sclPrev;
      sdaPrevFf <= nxt_sdaPrev;
      csPrevFf  <= nxt_csPrev;
    end
  end

  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;
  logic csRise;

  assign sclRise  = sclS && !sclPrevFf;
  assign sclFall  = !sclS && sclPrevFf;
  assign startDet = sclS && sclPrevFf && sdaPrevFf && !sdaS;
  assign stopDet  = sclS && sclPrevFf && !sdaPrevFf && sdaS;
  assign csRise   = csS && !csPrevFf;

  // Protocol engine and register side
  i2c_state_type stateFf;
  i2c_state_type nxt_state;
  logic [3:0]    bitCntFf;
  logic [3:0]    nxt_bitCnt;
  logic [7:0]    shiftFf;
  logic [7:0]    nxt_shift;
  logic [1:0]    byteIdxFf;
  logic [1:0]    nxt_byteIdx;
  logic          rwFf;
  logic          nxt_rw;
  logic          hiByteFf;
  logic          nxt_hiByte;
  logic [15:0]   ptrFf;
  logic [15:0]   nxt_ptr;
  logic [7:0]    dataHiFf;
  logic [7:0]    nxt_dataHi;
  logic [15:0]   rdWordFf;
  logic [15:0]   nxt_rdWord;
  logic          rdPendFf;
  logic          nxt_rdPend;
  logic [15:0]   regAddrFf;
  logic [15:0]   nxt_regAddr;
  logic [15:0]   regWrDataFf;
  logic [15:0]   nxt_regWrData;
  logic          regWrEnFf;
  logic          nxt_regWrEn;
  logic          regRdEnFf;
  logic          nxt_regRdEn;
  logic          sdaOeNFf;
  logic          nxt_sdaOeN;

  always_comb begin
    nxt_state     = stateFf;
    nxt_bitCnt    = bitCntFf;
    nxt_shift     = shiftFf;
    nxt_byteIdx   = byteIdxFf;
    nxt_rw        = rwFf;
    nxt_hiByte    = hiByteFf;
    nxt_ptr       = ptrFf;
    nxt_dataHi    = dataHiFf;
    nxt_rdWord    = rdWordFf;
    nxt_rdPend    = regRdEnFf;
    nxt_regAddr   = regAddrFf;
    nxt_regWrData = regWrDataFf;
    nxt_regWrEn   = 1'b0;
    nxt_regRdEn   = 1'b0;
    nxt_sdaOeN    = sdaOeNFf;

    // Read data is due one cycle after the request
    if (rdPendFf) begin
      nxt_rdWord = regRdData;
    end

    // Capture on select rising; word is quiet by then
    if (spiOn && csRise) begin
      nxt_regAddr   = spiShiftFf[SPI_ADDR_MSB:SPI_ADDR_LSB];
      nxt_regWrData = spiShiftFf[SPI_DATA_MSB:SPI_DATA_LSB];
      nxt_regWrEn   = 1'b1;
    end

    if (!i2cOn) begin
      // Serial mode never drives the data pin
      nxt_state  = ST_IDLE;
      nxt_sdaOeN = 1'b1;
    end else if (startDet) begin
      nxt_state  = ST_ADDR;
      nxt_bitCnt = 4'h0;
      nxt_sdaOeN = 1'b1;
    end else if (stopDet) begin
      nxt_state  = ST_IDLE;
      nxt_sdaOeN = 1'b1;
    end else begin
      unique case (stateFf)
        ST_IDLE: begin
          nxt_sdaOeN = 1'b1;
        end
        ST_ADDR: begin
          if (sclRise) begin
            nxt_shift  = {shiftFf[6:0], sdaS};
            nxt_bitCnt = bitCntFf + 4'h1;
          end else if (sclFall && bitCntFf == BYTE_BITS) begin
            if (shiftFf[7:1] == slaveAddr(csS)) begin
              nxt_sdaOeN  = SDA_DRIVE_LVL;
              nxt_state   = ST_ACK;
              nxt_rw      = shiftFf[0];
              nxt_hiByte  = 1'b1;
              nxt_byteIdx = IDX_ADDR_HI;
              if (shiftFf[0]) begin
                nxt_regAddr = ptrFf;
                nxt_regRdEn = 1'b1;
              end
            end else begin
              nxt_state = ST_IDLE;
            end
          end
        end
        ST_WRBYTE: begin
          if (sclRise) begin
            nxt_shift  = {shiftFf[6:0], sdaS};
            nxt_bitCnt = bitCntFf + 4'h1;
          end else if (sclFall && bitCntFf == BYTE_BITS) begin
            nxt_sdaOeN = SDA_DRIVE_LVL;
            nxt_state  = ST_ACK;
            unique case (byteIdxFf)
              IDX_ADDR_HI: nxt_ptr[15:8] = shiftFf;
              IDX_ADDR_LO: nxt_ptr[7:0]  = shiftFf;
              IDX_DATA_HI: nxt_dataHi    = shiftFf;
              IDX_DATA_LO: begin
                nxt_regAddr   = ptrFf;
                nxt_regWrData = {dataHiFf, shiftFf};
                nxt_regWrEn   = 1'b1;
                nxt_ptr       = ptrFf + 16'h0001;
              end
            endcase
            nxt_byteIdx = (byteIdxFf == IDX_DATA_LO) ? IDX_DATA_HI
                                                     : byteIdxFf + 2'h1;
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            nxt_bitCnt = 4'h0;
            if (rwFf) begin
              nxt_state  = ST_RDBYTE;
              nxt_sdaOeN = txBit(rdWordFf, hiByteFf, 3'h7);
            end else begin
              nxt_state  = ST_WRBYTE;
              nxt_sdaOeN = 1'b1;
            end
          end
        end
        ST_RDBYTE: begin
          if (sclRise) begin
            nxt_bitCnt = bitCntFf + 4'h1;
          end else if (sclFall) begin
            if (bitCntFf == BYTE_BITS) begin
              // Release so the master can answer
              nxt_sdaOeN = 1'b1;
              nxt_state  = ST_RDACK;
              nxt_bitCnt = 4'h0;
              nxt_hiByte = !hiByteFf;
              if (!hiByteFf) begin
                // Pair sent, step even if nacked
                nxt_ptr = ptrFf + 16'h0001;
              end
            end else begin
              nxt_sdaOeN = txBit(rdWordFf, hiByteFf, ~bitCntFf[2:0]);
            end
          end
        end
        ST_RDACK: begin
          if (sclRise) begin
            if (sdaS) begin
              nxt_state = ST_IDLE;
            end else begin
              nxt_bitCnt = 4'h1;
              if (hiByteFf) begin
                nxt_regAddr = ptrFf;
                nxt_regRdEn = 1'b1;
              end
            end
          end else if (sclFall && bitCntFf == 4'h1) begin
            nxt_state  = ST_RDBYTE;
            nxt_bitCnt = 4'h0;
            nxt_sdaOeN = txBit(rdWordFf, hiByteFf, 3'h7);
          end
        end
        default: begin
          nxt_state  = ST_IDLE;
          nxt_sdaOeN = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      stateFf     <= ST_IDLE;
      bitCntFf    <= 4'h0;
      shiftFf     <= 8'h00;
      byteIdxFf   <= IDX_ADDR_HI;
      rwFf        <= 1'b0;
      hiByteFf    <= 1'b1;
      ptrFf       <= PTR_RESET;
      dataHiFf    <= 8'h00;
      rdWordFf    <= 16'h0000;
      rdPendFf    <= 1'b0;
      regAddrFf   <= 16'h0000;
      regWrDataFf <= 16'h0000;
      regWrEnFf   <= 1'b0;
      regRdEnFf   <= 1'b0;
      sdaOeNFf    <= 1'b1;
    end else begin
      stateFf     <= nxt_state;
      bitCntFf    <= nxt_bitCnt;
      shiftFf     <= nxt_shift;
      byteIdxFf   <= nxt_byteIdx;
      rwFf        <= nxt_rw;
      hiByteFf    <= nxt_hiByte;
      ptrFf       <= nxt_ptr;
      dataHiFf    <= nxt_dataHi;
      rdWordFf    <= nxt_rdWord;
      rdPendFf    <= nxt_rdPend;
      regAddrFf   <= nxt_regAddr;
      regWrDataFf <= nxt_regWrData;
      regWrEnFf   <= nxt_regWrEn;
      regRdEnFf   <= nxt_regRdEn;
      sdaOeNFf    <= nxt_sdaOeN;
    end
  end

  // Open drain: the pin only ever pulls low
  logic sdaOutFf;
  logic nxt_sdaOut;

  // Slave only: clock pin is never driven
  always_comb begin
    nxt_sdaOut = SDA_DRIVE_LVL;
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      sdaOutFf <= SDA_DRIVE_LVL;
    end else begin
      sdaOutFf <= nxt_sdaOut;
    end
  end

  assign ctrlDataOut   = sdaOutFf;
  assign ctrlDataOeN   = sdaOeNFf;
  assign regAddr       = regAddrFf;
  assign regWrData     = regWrDataFf;
  assign regWrEn       = regWrEnFf;
  assign regRdEn       = regRdEnFf;
  assign spiModeActive = spiModeFf;

endmodule

// file: tb/codec_control_port_slave_sva.sv
module codec_control_port_slave_sva #(
  parameter bit SMALL_PACKAGE = 1'b0
) (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        ctrlClk,
  input wire logic        modeSelectPin,
  input wire logic        addressBitOrChipSelectPin,
  input wire logic        ctrlDataIn,
  input wire logic        ctrlDataOut,
  input wire logic        ctrlDataOeN,
  input wire logic [15:0] regRdData,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWrEn,
  input wire logic        regRdEn,
  input wire logic        spiModeActive
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  chk_mode_latch: assert property (
    rstn && !$past(rstn) |=>
      spiModeActive == (modeSelectPin && !SMALL_PACKAGE))
    else $error("mode not taken from strap");
  chk_mode_held: assert property (
    $past(rstn) && $past(rstn, 2) |-> $stable(spiModeActive))
    else $error("mode changed without reset");
  chk_spi_no_drive: assert property (
    spiModeActive |-> ctrlDataOeN)
    else $error("data pin driven in serial mode");
  chk_spi_no_read: assert property (
    spiModeActive |-> !regRdEn)
    else $error("read issued in serial mode");
  chk_spi_wr_delay: assert property (
    spiModeActive && $rose(addressBitOrChipSelectPin) |-> ##[1:6] regWrEn)
    else $error("no write after select rise");
  chk_wr_pulse_one: assert property (
    regWrEn |=> !regWrEn)
    else $error("write pulse too long");
  chk_rd_pulse_one: assert property (
    regRdEn |=> !regRdEn && !regWrEn)
    else $error("read pulse too long");
  chk_addr_hold: assert property (
    !regWrEn && !regRdEn |-> $stable({regAddr, regWrData}))
    else $error("address or data moved between pulses");
endmodule

bind codec_control_port_slave codec_control_port_slave_sva #(
  .SMALL_PACKAGE(SMALL_PACKAGE)
) chk (.clock, .rstn, .ctrlClk, .modeSelectPin, .addressBitOrChipSelectPin,
  .ctrlDataIn, .ctrlDataOut, .ctrlDataOeN, .regRdData, .regAddr,
  .regWrData, .regWrEn, .regRdEn, .spiModeActive);

// file: tb/host_master_model.sv
module host_master_model #(
  parameter int HALF = 120
) (
  output logic      ctrlClk,
  output logic      selectPin,
  output wire logic ctrlDataIn,
  input  wire logic ctrlDataOut,
  input  wire logic ctrlDataOeN
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sdaRel;

  // open-drain line, pull-up
  // Enabled driver shows its own level, so a wrong level breaks every ack
  assign ctrlDataIn = sdaRel & (ctrlDataOeN | ctrlDataOut);

  initial begin
    ctrlClk = 1'b1;
    selectPin = 1'b1;
    sdaRel = 1'b1;
  end

  task automatic bitIo(input logic b, output logic s);
    #(HALF / 4) sdaRel = b;
    #HALF ctrlClk = 1'b1;
    #HALF s = ctrlDataIn;
    ctrlClk = 1'b0;
  endtask

  task automatic xfer(input logic [7:0] d, input logic a,
                      output logic [7:0] r, output logic s);
    for (int i = 7; i >= 0; i--) bitIo(d[i], r[i]);
    bitIo(a, s);
  endtask

  task automatic sendStart;
    #(HALF / 4) sdaRel = 1'b1;
    #HALF ctrlClk = 1'b1;
    #HALF sdaRel = 1'b0;
    #HALF ctrlClk = 1'b0;
  endtask

  task automatic sendStop;
    #(HALF / 4) sdaRel = 1'b0;
    #HALF ctrlClk = 1'b1;
    #HALF sdaRel = 1'b1;
    #HALF;
  endtask

  // select low, MSB first, clock idle low
  task automatic spiFrame(input logic [35:0] w, input int n);
    ctrlClk = 1'b0;
    #32 selectPin = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdaRel = w[i];
      #32 ctrlClk = 1'b1;
      #32 ctrlClk = 1'b0;
    end
    #32 selectPin = 1'b1;
    // Released line shows the inverse so a stale bit is never trusted
    sdaRel = ~sdaRel;
  endtask
endmodule

// file: tb/tb_codec_control_port_slave.sv
module tb_codec_control_port_slave;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock;
  logic        rstn;
  logic        modeSelectPin;
  logic [15:0] regRdData;
  wire         ctrlClk;
  wire         addressBitOrChipSelectPin;
  wire         ctrlDataIn;
  logic        ctrlDataOut, ctrlDataOeN, regWrEn, regRdEn, spiModeActive;
  logic [15:0] regAddr, regWrData;
  logic [31:0] wrQ[$];
  logic [31:0] rows[3] = '{32'h0002_1234, 32'hFFFF_0000, 32'h8000_A5A5};
  logic [7:0]  r;
  logic        s;
  logic        smallOeN;
  logic        smallSpi;
  logic        smallAck;
  int          fail_count;
  int          num_checks;

  codec_control_port_slave uut (.clock, .rstn, .ctrlClk, .modeSelectPin,
    .addressBitOrChipSelectPin, .ctrlDataIn, .ctrlDataOut, .ctrlDataOeN,
    .regRdData, .regAddr, .regWrData, .regWrEn, .regRdEn, .spiModeActive);
  // Small package variant listens on the same pins but never drives them
  codec_control_port_slave #(
    .SMALL_PACKAGE (1'b1)
  ) uutSmall (.clock, .rstn, .ctrlClk, .modeSelectPin,
    .addressBitOrChipSelectPin, .ctrlDataIn, .ctrlDataOut(),
    .ctrlDataOeN(smallOeN), .regRdData, .regAddr(), .regWrData(),
    .regWrEn(), .regRdEn(), .spiModeActive(smallSpi));
  host_master_model host (.ctrlClk, .selectPin(addressBitOrChipSelectPin),
    .ctrlDataIn, .ctrlDataOut, .ctrlDataOeN);

  always #5 clock = ~clock;

  function automatic logic [15:0] rdModel(input logic [15:0] a);
    return {a[7:0], ~a[15:8]};
  endfunction

  always @(posedge clock) begin
    // Register file answers only a read pulse, then holds its word
    #1 if (regRdEn === 1'b1) regRdData = rdModel(regAddr);
    if (regWrEn === 1'b1) wrQ.push_back({regAddr, regWrData});
    if (smallOeN === 1'b0) smallAck = 1'b1;
  end

  task automatic check(input string what, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic summarize;
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic doReset(input logic strap);
    @(posedge clock);
    #1 rstn = 1'b0;
    modeSelectPin = strap;
    repeat (12) @(posedge clock);
    #1 check("oe in reset", 32'h1, {31'h0, ctrlDataOeN});
    rstn = 1'b1;
    repeat (3) @(posedge clock);
    #1 check("mode", {31'h0, strap}, {31'h0, spiModeActive});
  endtask

  task automatic sendByte(input logic [7:0] d);
    logic [7:0] q;
    logic       a;
    host.xfer(d, 1'b1, q, a);
    check("ack", 32'h0, {31'h0, a});
  endtask

  task automatic i2cWrite(input logic [15:0] p, input logic [31:0] d,
                          input int n);
    host.sendStart();
    sendByte(8'h54);
    sendByte(p[15:8]);
    sendByte(p[7:0]);
    for (int i = n - 1; i >= 0; i--) sendByte(d[8*i +: 8]);
    host.sendStop();
  endtask

  task automatic expectWr(input logic [31:0] e);
    check("write seen", 32'h1, {31'h0, wrQ.size() != 0});
    if (wrQ.size() != 0) check("write", e, wrQ.pop_front());
  endtask

  task automatic readWord(input logic [15:0] a, input logic last);
    logic [7:0] hi;
    logic [7:0] lo;
    logic       a2;
    host.xfer(8'hFF, 1'b0, hi, a2);
    host.xfer(8'hFF, last, lo, a2);
    check("read", {16'h0, rdModel(a)}, {16'h0, hi, lo});
  endtask

  task automatic waitWr;
    for (int i = 0; i < 20 && wrQ.size() == 0; i++) @(posedge clock);
    if (wrQ.size() == 0) begin
      fail_count++;
      summarize();
    end
  endtask

  initial begin
    clock = 1'b0;
    rstn = 1'b0;
    modeSelectPin = 1'b0;
    regRdData = 16'h0000;
    fail_count = 0;
    num_checks = 0;
    smallAck = 1'b0;
    doReset(1'b0);
    foreach (rows[i]) begin
      i2cWrite(rows[i][31:16], rows[i], 2);
      expectWr(rows[i]);
    end
    i2cWrite(16'h0010, 32'hABCD_1234, 4);
    expectWr(32'h0010_ABCD);
    expectWr(32'h0011_1234);
    i2cWrite(16'h0030, 32'h0000_0077, 1);
    check("no write", 32'h0, 32'(wrQ.size()));
    check("small ack early", 32'h0, {31'h0, smallAck});
    host.sendStart();
    host.xfer(8'h14, 1'b1, r, s);
    check("nack", 32'h1, {31'h0, s});
    check("small ack", 32'h1, {31'h0, smallAck});
    host.sendStop();
    i2cWrite(16'h0020, 32'h0, 0);
    host.sendStart();
    sendByte(8'h55);
    readWord(16'h0020, 1'b0);
    readWord(16'h0021, 1'b1);
    host.sendStop();
    host.sendStart();
    sendByte(8'h55);
    readWord(16'h0022, 1'b1);
    host.sendStop();
    doReset(1'b1);
    check("small mode", 32'h0, {31'h0, smallSpi});
    host.spiFrame(36'hF_1234_5678, 36);
    waitWr();
    expectWr(32'h1234_5678);
    host.spiFrame(36'h0_FFFF_0001, 32);
    waitWr();
    expectWr(32'hFFFF_0001);
    #1 modeSelectPin = 1'b0;
    repeat (8) @(posedge clock);
    #1 check("mode held", 32'h1, {31'h0, spiModeActive});
    doReset(1'b0);
    summarize();
  end
endmodule
